// >>> hdl/status_report.sv
// status reporting and remote state of a bus instrument
// assumes a command decoder supplies one-cycle strobes and data
`timescale 1ns/1ps
`default_nettype none
module status_report
  import status_pkg::*;
(
  input  wire logic          SYS_CLK,
  input  wire logic          RST,
  input  wire logic          CMD_ERR,
  input  wire logic          EXEC_ERR,
  input  wire logic          ALARM,
  input  wire logic          OP_DONE,
  input  wire logic          BUS_ERR,
  input  wire logic          BUS_TMO,
  input  wire logic          QUEUE_NOT_EMPTY,
  input  wire logic          EV_MASK_WR,
  input  wire logic          SRQ_MASK_WR,
  input  wire logic [7:0]    WR_DATA,
  input  wire logic          EV_QUERY,
  input  wire logic          EV_MASK_QUERY,
  input  wire logic          SRQ_MASK_QUERY,
  input  wire logic          STB_QUERY,
  input  wire logic          SERIAL_POLL,
  input  wire logic          CLEAR_STATUS,
  input  wire logic          IFC,
  input  wire logic          DEV_CLEAR,
  input  wire logic          RESET_CMD,
  input  wire logic          REN,
  input  wire logic          LISTEN_ADDR,
  input  wire logic          TALK_ADDR,
  input  wire logic          UNADDRESS,
  input  wire logic          GO_LOCAL,
  input  wire logic          LOCAL_KEY,
  input  wire logic          LOCKOUT_CMD,
  output logic [7:0]         RD_DATA,
  output logic               RD_VALID,
  output logic               SRQ,
  output logic               LISTENER,
  output logic               TALKER,
  output logic               FLUSH,
  output logic               PANEL_ENABLE,
  output logic               LOCAL_KEY_ENABLE,
  output logic [1:0]         REMOTE_STATE
);
  import status_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] ev_mask;
    logic [7:0] srq_mask;
    logic       request_service_bit;
    logic       mss_prev;
    logic       sb_inhibit;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       srq;
    logic       listener;
    logic       talker;
    logic       flush;
    logic       panel_en;
    logic       key_en;
    logic [1:0] rstate;
  } sr_state_t;

  sr_state_t     st_r;
  sr_state_t     st_nxt;
  logic [7:0]    ev_flags;
  logic [7:0]    ev_set;
  logic          ev_clr;
  logic [7:0]    status_byte;
  logic          event_summary_bit;
  logic          master_summary_bit;
  remote_state_t rstate;

  // ==========================================================
  // event register
  always_comb begin
    ev_set = ZERO_BYTE;
    ev_set[EV_CMD_ERR] = CMD_ERR;
    ev_set[EV_EXEC_ERR] = EXEC_ERR;
    ev_set[EV_ALARM] = ALARM;
    ev_set[EV_OP_DONE] = OP_DONE;
  end

  assign ev_clr = CLEAR_STATUS | DEV_CLEAR | RESET_CMD;

  event_reg u_event (
    .clk      (SYS_CLK),
    .rst      (RST),
    .set_in   (ev_set),
    .read_clr (EV_QUERY),
    .clr      (ev_clr),
    .flags    (ev_flags)
  );

  remote_fsm u_remote (
    .clk         (SYS_CLK),
    .rst         (RST),
    .ren         (REN),
    .listen_addr (LISTEN_ADDR),
    .go_local    (GO_LOCAL),
    .local_key   (LOCAL_KEY),
    .lockout_cmd (LOCKOUT_CMD),
    .dev_clear   (DEV_CLEAR),
    .state       (rstate)
  );

  // ==========================================================
  // status byte summaries
  // event summary bit
  assign event_summary_bit = |(ev_flags & st_r.ev_mask);

  always_comb begin
    status_byte = ZERO_BYTE;
    if (!st_r.sb_inhibit) begin
      status_byte[SB_EVENT_SUM] = event_summary_bit;
      status_byte[SB_MSG_AVAIL] = QUEUE_NOT_EMPTY;
      status_byte[SB_BUS_ERR]   = BUS_ERR;
      status_byte[SB_BUS_TMO]   = BUS_TMO;
    end
  end

  assign master_summary_bit = |(status_byte & st_r.srq_mask & SB_SRQ_MASK);

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.flush = 1'b0;
    st_nxt.mss_prev = master_summary_bit;
    // status byte clears hold until its sources (queue, bus error, bus timeout) are all low
    if (st_r.sb_inhibit && !QUEUE_NOT_EMPTY && !BUS_ERR && !BUS_TMO) begin
      st_nxt.sb_inhibit = 1'b0;
    end
    if (!master_summary_bit) begin
      st_nxt.request_service_bit = 1'b0;
    end else if (SERIAL_POLL) begin
      st_nxt.request_service_bit = 1'b0;
    end
    if (master_summary_bit && !st_r.mss_prev) begin
      st_nxt.request_service_bit = 1'b1;
    end
    if (EV_MASK_WR) begin
      st_nxt.ev_mask = WR_DATA;
    end
    if (SRQ_MASK_WR) begin
      st_nxt.srq_mask = WR_DATA;
    end
    if (EV_QUERY) begin
      st_nxt.rd_data = ev_flags;
      st_nxt.rd_valid = 1'b1;
    end else if (EV_MASK_QUERY) begin
      st_nxt.rd_data = st_r.ev_mask;
      st_nxt.rd_valid = 1'b1;
    end else if (SRQ_MASK_QUERY) begin
      st_nxt.rd_data = st_r.srq_mask;
      st_nxt.rd_valid = 1'b1;
    end else if (STB_QUERY) begin
      // summary in bit 6, no clear
      st_nxt.rd_data = status_byte;
      st_nxt.rd_data[SB_SUMMARY] = master_summary_bit;
      st_nxt.rd_valid = 1'b1;
    end else if (SERIAL_POLL) begin
      st_nxt.rd_data = status_byte;
      st_nxt.rd_data[SB_SUMMARY] = st_r.request_service_bit;
      st_nxt.rd_valid = 1'b1;
    end
    if (LISTEN_ADDR) begin
      st_nxt.listener = 1'b1;
    end
    if (TALK_ADDR) begin
      st_nxt.talker = 1'b1;
    end
    if (IFC || UNADDRESS) begin
      st_nxt.listener = 1'b0;
      st_nxt.talker = 1'b0;
    end
    if (CLEAR_STATUS) begin
      st_nxt.sb_inhibit = 1'b1;
      st_nxt.request_service_bit = 1'b0;
      // re-arm the edge so an event landing with the clear still requests
      st_nxt.mss_prev = 1'b0;
    end
    if (DEV_CLEAR || RESET_CMD) begin
      st_nxt.listener = 1'b0;
      st_nxt.talker = 1'b0;
      st_nxt.flush = 1'b1;
      st_nxt.request_service_bit = 1'b0;
      st_nxt.sb_inhibit = 1'b1;
      st_nxt.mss_prev = 1'b0;
    end
    if (RESET_CMD) begin
      st_nxt.ev_mask = MASK_RESET;
      st_nxt.srq_mask = MASK_RESET;
    end
    st_nxt.srq = st_nxt.request_service_bit;
    st_nxt.rstate = rstate;
    st_nxt.panel_en = (rstate == RS_LOCAL);
    st_nxt.key_en = (rstate != RS_LOCKOUT);
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      st_r.ev_mask <= MASK_RESET;
      st_r.srq_mask <= MASK_RESET;
      st_r.request_service_bit <= 1'b0;
      st_r.mss_prev <= 1'b0;
      st_r.sb_inhibit <= 1'b0;
      st_r.rd_data <= ZERO_BYTE;
      st_r.rd_valid <= 1'b0;
      st_r.srq <= 1'b0;
      st_r.listener <= 1'b0;
      st_r.talker <= 1'b0;
      st_r.flush <= 1'b1;
      st_r.panel_en <= 1'b1;
      st_r.key_en <= 1'b1;
      st_r.rstate <= RS_LOCAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign RD_DATA = st_r.rd_data;
  assign RD_VALID = st_r.rd_valid;
  assign SRQ = st_r.srq;
  assign LISTENER = st_r.listener;
  assign TALKER = st_r.talker;
  assign FLUSH = st_r.flush;
  assign PANEL_ENABLE = st_r.panel_en;
  assign LOCAL_KEY_ENABLE = st_r.key_en;
  assign REMOTE_STATE = st_r.rstate;

  // ==========================================================
  // checks
  property p_ev_bits;
    @(posedge SYS_CLK) disable iff (RST) (ev_flags & ~EV_USED_MASK) == ZERO_BYTE;
  endproperty
  a_ev_bits: assert property (p_ev_bits) else $error("unused event bit set");

  property p_ev_clear;
    @(posedge SYS_CLK) disable iff (RST)
      EV_QUERY && ev_set == ZERO_BYTE |=> ev_flags == ZERO_BYTE;
  endproperty
  a_ev_clear: assert property (p_ev_clear) else $error("event query did not clear");

  property p_exec;
    @(posedge SYS_CLK) disable iff (RST) EXEC_ERR |=> ev_flags[EV_EXEC_ERR];
  endproperty
  a_exec: assert property (p_exec) else $error("exec error not flagged");

  property p_mask_rd;
    @(posedge SYS_CLK) disable iff (RST)
      EV_MASK_WR && !RESET_CMD ##1 !EV_MASK_WR && !RESET_CMD
      ##1 EV_MASK_QUERY && !EV_QUERY && !EV_MASK_WR && !RESET_CMD
      |=> RD_VALID && RD_DATA == $past(WR_DATA, 3);
  endproperty
  a_mask_rd: assert property (p_mask_rd) else $error("mask readback wrong");

  property p_srq_rise;
    @(posedge SYS_CLK) disable iff (RST)
      $rose(master_summary_bit) && !CLEAR_STATUS && !DEV_CLEAR && !RESET_CMD |=> SRQ;
  endproperty
  a_srq_rise: assert property (p_srq_rise) else $error("no request on summary rise");

  property p_stb_q;
    @(posedge SYS_CLK) disable iff (RST)
      STB_QUERY && !EV_QUERY && !EV_MASK_QUERY && !SRQ_MASK_QUERY
      |=> RD_DATA[SB_SUMMARY] == $past(master_summary_bit);
  endproperty
  a_stb_q: assert property (p_stb_q) else $error("status query summary wrong");

  property p_mss_off;
    @(posedge SYS_CLK) disable iff (RST)
      ev_flags == ZERO_BYTE && !QUEUE_NOT_EMPTY && !BUS_ERR && !BUS_TMO
      |-> !master_summary_bit ##1 !SRQ;
  endproperty
  a_mss_off: assert property (p_mss_off) else $error("summary without source");

  property p_dcl;
    @(posedge SYS_CLK) disable iff (RST)
      DEV_CLEAR |=> !LISTENER && !SRQ ##1 REMOTE_STATE == RS_LOCAL;
  endproperty
  a_dcl: assert property (p_dcl) else $error("device clear incomplete");

  property p_rst_mask;
    @(posedge SYS_CLK) disable iff (RST)
      RESET_CMD |=> st_r.ev_mask == MASK_RESET && st_r.srq_mask == MASK_RESET;
  endproperty
  a_rst_mask: assert property (p_rst_mask) else $error("reset left masks");

  property p_ifc;
    @(posedge SYS_CLK) disable iff (RST)
      IFC && !DEV_CLEAR && !RESET_CMD && REN && !GO_LOCAL && !LOCAL_KEY
      && rstate == RS_LOCKOUT |=> rstate == RS_LOCKOUT && !LISTENER;
  endproperty
  a_ifc: assert property (p_ifc) else $error("interface clear changed lockout");
endmodule : status_report
`default_nettype wire

// >>> hdl/status_pkg.sv
// constants for the instrument status reporting block
// assumes one clock, synchronous reset, command strobes decoded upstream
package status_pkg;
  // event register bit positions
  localparam int unsigned EV_POWER_ON   = 7;
  localparam int unsigned EV_CMD_ERR    = 5;
  localparam int unsigned EV_EXEC_ERR   = 4;
  localparam int unsigned EV_ALARM      = 3;
  localparam int unsigned EV_OP_DONE    = 0;
  localparam logic [7:0]  EV_USED_MASK  = 8'hb9;
  localparam logic [7:0]  EV_RESET_VAL  = 8'h80;
  // status byte bit positions
  localparam int unsigned SB_EVENT_SUM  = 5;
  localparam int unsigned SB_MSG_AVAIL  = 4;
  localparam int unsigned SB_BUS_ERR    = 1;
  localparam int unsigned SB_BUS_TMO    = 0;
  localparam int unsigned SB_SUMMARY    = 6;
  localparam logic [7:0]  SB_SRQ_MASK   = 8'h33;
  localparam logic [7:0]  MASK_RESET    = 8'h00;
  localparam logic [7:0]  ZERO_BYTE     = 8'h00;
  typedef enum logic [1:0] {
    RS_LOCAL   = 2'b00,
    RS_REMOTE  = 2'b01,
    RS_LOCKOUT = 2'b10
  } remote_state_t;
endpackage : status_pkg

// >>> hdl/event_reg.sv
// sticky event register with read-to-clear
// assumes event pulses are synchronous to SYS_CLK
`timescale 1ns/1ps
`default_nettype none
module event_reg (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] set_in,
  input  wire logic       read_clr,
  input  wire logic       clr,
  output logic      [7:0] flags
);
  import status_pkg::*;
  typedef struct packed {
    logic [7:0] flags;
  } ev_state_t;
  ev_state_t st_r;
  ev_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (read_clr || clr) begin
      st_nxt.flags = ZERO_BYTE;
    end
    // set wins over a clear in the same cycle
    st_nxt.flags = (st_nxt.flags | set_in) & EV_USED_MASK;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.flags <= EV_RESET_VAL;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign flags = st_r.flags;
endmodule : event_reg
`default_nettype wire

// >>> hdl/remote_fsm.sv
// local / remote / lockout state machine
// assumes bus commands arrive as one-cycle strobes
`timescale 1ns/1ps
`default_nettype none
module remote_fsm
  import status_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          ren,
  input  wire logic          listen_addr,
  input  wire logic          go_local,
  input  wire logic          local_key,
  input  wire logic          lockout_cmd,
  input  wire logic          dev_clear,
  output remote_state_t      state
);
  typedef struct packed {
    remote_state_t rs;
  } rm_state_t;
  rm_state_t st_r;
  rm_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    unique case (st_r.rs)
      RS_LOCAL: begin
        if (ren && lockout_cmd) begin
          st_nxt.rs = RS_LOCKOUT;
        end else if (ren && listen_addr && !go_local) begin
          st_nxt.rs = RS_REMOTE;
        end
      end
      RS_REMOTE: begin
        if (local_key || go_local) begin
          st_nxt.rs = RS_LOCAL;
        end else if (lockout_cmd) begin
          st_nxt.rs = RS_LOCKOUT;
        end
      end
      RS_LOCKOUT: begin
        // panel local key has no effect here
        if (go_local) begin
          st_nxt.rs = RS_LOCAL;
        end
      end
      default: st_nxt.rs = RS_LOCAL;
    endcase
    if (!ren || dev_clear) begin
      st_nxt.rs = RS_LOCAL;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r.rs <= RS_LOCAL;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign state = st_r.rs;
endmodule : remote_fsm
`default_nettype wire

// >>> bench/bus_ctrl_model.sv
// bus controller model: issues one-cycle command strobes and collects answers
// assumes the bench maps strobe vector bits onto the command inputs
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  input  wire logic        clk,
  input  wire logic        rd_valid,
  input  wire logic [7:0]  rd_data,
  output logic      [16:0] strb,
  output logic      [7:0]  wr_data
);
  // ==========================================
  // command and query tasks
  initial begin
    strb    = '0;
    wr_data = 8'h00;
  end

  task automatic send(input int idx, input logic [7:0] d);
    @(posedge clk);
    #1;
    strb[idx] = 1'b1;
    wr_data   = d;
    @(posedge clk);
    #1;
    strb[idx] = 1'b0;
    // released data bus must not keep showing the last byte
    wr_data   = ~d;
  endtask : send

  task automatic ask(input int idx, output logic [7:0] v);
    int i;
    send(idx, 8'h00);
    for (i = 0; i < 4 && rd_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    v = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask : ask
endmodule : bus_ctrl_model
`default_nettype wire

// >>> bench/status_report_bench.sv
// testbench for the status reporting block
// assumes strobes are one cycle wide and answers follow one cycle later
`timescale 1ns/1ps
`default_nettype none
module status_report_bench;
  import status_pkg::*;
  localparam int EV_WR = 0, SRQ_WR = 1, EV_Q = 2, EV_MQ = 3, SRQ_MQ = 4, STB_Q = 5;
  localparam int POLL = 6, CLS = 7, IFC_C = 8, DCL = 9, RST_C = 10, LSN = 11;
  localparam int TLK = 12, UNA = 13, GTL = 14, KEY = 15, LLO = 16;
  logic        sys_clk, rst, ren, rd_valid, srq, listener, talker, flush, panel, key_en;
  logic [7:0]  ev, st, rd_data, wr_data;
  logic [1:0]  remote_state;
  logic [16:0] strb;
  logic [7:0]  vals [3] = '{8'h00, 8'h30, 8'hff};
  int          n_errors, checks, n_flush;

  // ==========================================
  // design and controller model
  status_report status_report_i (
    .SYS_CLK(sys_clk), .RST(rst), .CMD_ERR(ev[5]), .EXEC_ERR(ev[4]), .ALARM(ev[3]),
    .OP_DONE(ev[0]), .BUS_ERR(st[1]), .BUS_TMO(st[0]), .QUEUE_NOT_EMPTY(st[4]),
    .EV_MASK_WR(strb[EV_WR]), .SRQ_MASK_WR(strb[SRQ_WR]), .WR_DATA(wr_data),
    .EV_QUERY(strb[EV_Q]), .EV_MASK_QUERY(strb[EV_MQ]), .SRQ_MASK_QUERY(strb[SRQ_MQ]),
    .STB_QUERY(strb[STB_Q]), .SERIAL_POLL(strb[POLL]), .CLEAR_STATUS(strb[CLS]),
    .IFC(strb[IFC_C]), .DEV_CLEAR(strb[DCL]), .RESET_CMD(strb[RST_C]), .REN(ren),
    .LISTEN_ADDR(strb[LSN]), .TALK_ADDR(strb[TLK]), .UNADDRESS(strb[UNA]),
    .GO_LOCAL(strb[GTL]), .LOCAL_KEY(strb[KEY]), .LOCKOUT_CMD(strb[LLO]),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .SRQ(srq), .LISTENER(listener),
    .TALKER(talker), .FLUSH(flush), .PANEL_ENABLE(panel), .LOCAL_KEY_ENABLE(key_en),
    .REMOTE_STATE(remote_state)
  );
  bus_ctrl_model bus_ctrl_model_i (
    .clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data), .strb(strb), .wr_data(wr_data)
  );

  always #4 sys_clk = ~sys_clk;
  // flush is a one-cycle pulse, so it is counted rather than sampled
  always @(negedge sys_clk) if (flush === 1'b1) n_flush++;

  // ==========================================
  // helpers
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic send(input int idx, input logic [7:0] d);
    bus_ctrl_model_i.send(idx, d);
  endtask : send
  task automatic q(input int idx, input string nm, input logic [7:0] e);
    logic [7:0] v;
    bus_ctrl_model_i.ask(idx, v);
    chk(nm, e, v);
  endtask : q
  task automatic w;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : w
  task automatic pulse(input logic [7:0] v);
    @(posedge sys_clk);
    #1;
    ev = v;
    @(posedge sys_clk);
    #1;
    ev = 8'h00;
  endtask : pulse
  // packs state, listener, talker, panel and key enable
  task automatic rs(input logic [7:0] e);
    chk("remote", e, {2'h0, remote_state, listener, talker, panel, key_en});
  endtask : rs
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // ==========================================
  // tests
  initial begin
    #20000;
    n_errors++;
    finish_test;
  end
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    ren = 1'b0;
    ev = 8'h00;
    st = 8'h00;
    repeat (8) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    q(EV_Q, "ev_flags", 8'h80);
    q(EV_Q, "ev_reread", 8'h00);
    q(EV_MQ, "ev_mask", 8'h00);
    q(SRQ_MQ, "srq_mask", 8'h00);
    q(STB_Q, "stb", 8'h00);
    rs(8'h03);
    pulse(8'hff);
    q(EV_Q, "ev_layout", 8'h39);
    $display("test power_on done");
    // query straight after the write so the readback property is reached
    foreach (vals[i]) begin
      send(EV_WR, vals[i]);
      q(EV_MQ, "ev_mask", vals[i]);
      send(SRQ_WR, ~vals[i]);
      q(SRQ_MQ, "srq_mask", ~vals[i]);
    end
    $display("test masks done");
    send(EV_WR, 8'h10);
    send(SRQ_WR, 8'h20);
    pulse(8'h20);
    w();
    q(STB_Q, "stb_masked", 8'h00);
    q(EV_Q, "ev_cmd", 8'h20);
    pulse(8'h10);
    w();
    chk("srq", 8'h01, {7'h0, srq});
    q(STB_Q, "stb", 8'h60);
    q(STB_Q, "stb_again", 8'h60);
    q(POLL, "poll", 8'h60);
    w();
    chk("srq_polled", 8'h00, {7'h0, srq});
    q(POLL, "poll_again", 8'h20);
    q(STB_Q, "stb_mss", 8'h60);
    q(EV_Q, "ev_exec", 8'h10);
    w();
    q(STB_Q, "stb_fallen", 8'h00);
    $display("test summary done");
    send(SRQ_WR, 8'hcc);
    st = 8'h13;
    w();
    chk("srq_unused", 8'h00, {7'h0, srq});
    q(STB_Q, "stb_src", 8'h13);
    send(SRQ_WR, 8'h33);
    w();
    q(STB_Q, "stb_src_mss", 8'h53);
    st = 8'h00;
    w();
    q(STB_Q, "stb_drained", 8'h00);
    chk("srq_drained", 8'h00, {7'h0, srq});
    $display("test sources done");
    st = 8'h10;
    pulse(8'h10);
    w();
    n_flush = 0;
    send(CLS, 8'h00);
    w();
    q(EV_Q, "ev_cls", 8'h00);
    q(STB_Q, "stb_cls", 8'h00);
    chk("flush_cls", 8'h00, 8'(n_flush));
    st = 8'h00;
    $display("test clear_status done");
    ren = 1'b1;
    send(LSN, 8'h00);
    w();
    rs(8'h19);
    send(LLO, 8'h00);
    w();
    rs(8'h28);
    send(KEY, 8'h00);
    w();
    rs(8'h28);
    send(IFC_C, 8'h00);
    w();
    rs(8'h20);
    chk("flush_ifc", 8'h00, 8'(n_flush));
    pulse(8'h10);
    w();
    send(DCL, 8'h00);
    w();
    rs(8'h03);
    chk("srq_dcl", 8'h00, {7'h0, srq});
    chk("flush_dcl", 8'h01, 8'(n_flush));
    q(STB_Q, "stb_dcl", 8'h00);
    send(LSN, 8'h00);
    send(EV_WR, 8'hff);
    send(RST_C, 8'h00);
    w();
    rs(8'h11);
    q(EV_MQ, "ev_mask_rst", 8'h00);
    q(SRQ_MQ, "srq_mask_rst", 8'h00);
    chk("flush_rst", 8'h02, 8'(n_flush));
    send(GTL, 8'h00);
    w();
    rs(8'h03);
    send(LSN, 8'h00);
    send(KEY, 8'h00);
    w();
    rs(8'h0b);
    send(LSN, 8'h00);
    w();
    rs(8'h19);
    ren = 1'b0;
    w();
    rs(8'h0b);
    send(TLK, 8'h00);
    w();
    rs(8'h0f);
    send(UNA, 8'h00);
    w();
    rs(8'h03);
    $display("test remote done");
    send(EV_WR, 8'hff);
    send(SRQ_WR, 8'hff);
    rst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    rs(8'h03);
    q(EV_MQ, "ev_mask_pon", 8'h00);
    q(SRQ_MQ, "srq_mask_pon", 8'h00);
    q(EV_Q, "ev_pon", 8'h80);
    $display("test power_cycle done");
    finish_test;
  end
endmodule : status_report_bench
`default_nettype wire
